// file: core/uiec_in_endpoint.sv
// IN endpoint control: NAK, disable, flush, size/count accounting, TX FIFO
`timescale 1ns/1ps
module uiec_in_endpoint import uiec_pkg::*; (
	input  wire logic                clk,             // Core clock
	input  wire logic                reset_n,         // Sync reset
	input  wire logic [ADDR_W-1:0]   avs_address,     // Byte address
	input  wire logic                avs_read,        // Read request
	input  wire logic                avs_write,       // Write request
	input  wire logic [3:0]          avs_byteenable,  // Byte lanes
	input  wire logic [31:0]         avs_writedata,   // Write data
	output logic [31:0]              avs_readdata,    // Read data
	output logic                     avs_waitrequest, // Slave stall
	input  wire uiec_link_in_t       linkIn,          // Token/ack/timeout
	output uiec_resp_t               resp,            // Token answer
	output uiec_tx_t                 tx,              // Packet words
	output logic                     irqOut           // Masked events
);

	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} uiec_state_t;

	function automatic logic [WCNT_W-1:0] wordsOf(input logic [LEN_W-1:0] n);
		logic [LEN_W:0] s;
		s = {1'b0, n} + (LEN_W+1)'(3);
		return WCNT_W'(s >> 2);
	endfunction : wordsOf

	function automatic logic isPeriodic(input logic [1:0] t);
		return (t == TYPE_ISO) || (t == TYPE_INTR);
	endfunction : isPeriodic

	// =====================================================================
	// State
	logic                 waitQ;
	logic                 enQ, disReqQ, nakQ, nakEffDoneQ;
	logic [TYPE_W-1:0]    typeQ;
	logic [MPS_W-1:0]     mpsQ;
	logic [IRQ_W-1:0]     irqStsQ, irqMaskQ;
	logic [SZ_W-1:0]      sizeQ;
	logic [PC_W-1:0]      pcntQ;
	logic [MC_W-1:0]      mcntQ;
	logic                 flushQ;
	logic [FSEL_W-1:0]    fselQ;
	logic [31:0]          memQ [FIFO_DEPTH];
	logic [PTR_W:0]       wrPtrQ, rdPtrQ, startPtrQ;
	logic [LEN_W-1:0]     lenQ [PKT_MAX];
	logic [PQ_W-1:0]      lenWrQ, lenRdQ;
	logic [PCNT_W-1:0]    pktsQ;
	logic                 zlpQ;
	uiec_state_t          stateQ;
	logic [WCNT_W-1:0]    sendLeftQ;

	// =====================================================================
	// Bus decode: one wait state, access completes when waitrequest is low
	logic        wrAcc;
	logic        wCtrl, wIrq, wMask, wSize, wRst, wData, wCommit;
	logic [31:0] wd, rdMux;
	logic [PTR_W:0] usedW;
	always_comb begin
		wd      = avs_writedata;
		wrAcc   = avs_write && !waitQ && (avs_byteenable == BE_ALL);
		wCtrl   = wrAcc && (avs_address == A_CTRL);
		wIrq    = wrAcc && (avs_address == A_IRQ);
		wMask   = wrAcc && (avs_address == A_MASK);
		wSize   = wrAcc && (avs_address == A_SIZE);
		wRst    = wrAcc && (avs_address == A_RSTCTL);
		wData   = wrAcc && (avs_address == A_FIFODATA);
		wCommit = wrAcc && (avs_address == A_COMMIT);
		usedW   = wrPtrQ - startPtrQ;
	end
	always_comb begin
		rdMux = 32'h0000_0000;
		unique case (avs_address)
			A_CTRL: begin
				rdMux[CTRL_EN]                   = enQ;
				rdMux[CTRL_DIS]                  = disReqQ;
				rdMux[CTRL_NAK_STATE_FLAG]               = nakQ;
				rdMux[CTRL_TYPE +: TYPE_W]       = typeQ;
				rdMux[CTRL_MPS +: MPS_W]         = mpsQ;
			end
			A_IRQ:  rdMux[IRQ_W-1:0] = irqStsQ;
			A_MASK: rdMux[IRQ_W-1:0] = irqMaskQ;
			A_SIZE: begin
				rdMux[SZ_LO +: SZ_W] = sizeQ;
				rdMux[PC_LO +: PC_W] = pcntQ;
				rdMux[MC_LO +: MC_W] = mcntQ;
			end
			A_RSTCTL: begin
				rdMux[RST_FLUSH]          = flushQ;
				rdMux[RST_FSEL +: FSEL_W] = fselQ;
			end
			A_FIFOSTS: begin
				rdMux[PTR_W:0]              = (PTR_W+1)'(FIFO_DEPTH) - usedW;
				rdMux[STS_PKT +: PCNT_W]    = pktsQ;
				rdMux[STS_ZLP]              = zlpQ;
			end
			default: rdMux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			waitQ        <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			waitQ <= !((avs_read || avs_write) && waitQ);
			if ((avs_read || avs_write) && waitQ)
				avs_readdata <= avs_read ? rdMux : 32'h0000_0000;
		end
	end
	assign avs_waitrequest = waitQ;

	// =====================================================================
	// Event decode
	logic idle, iso, fifoFull, tok, tkRefuse, tkZlpFlag, tkData, tkEmpty;
	logic ackEv, toEv, isoDone, pktDone, pcntDec, commitOk, emptyIrq;
	logic nakEffEv, disEv, xferEv, flushEv, popPkt, frameShort;
	logic [LEN_W-1:0] commitLen;
	always_comb begin
		idle      = (stateQ == ST_IDLE);
		iso       = (typeQ == TYPE_ISO);
		fifoFull  = (usedW == (PTR_W+1)'(FIFO_DEPTH));
		// A periodic frame is present only once all its bytes are written:
		// one missing word makes the token see an empty FIFO.
		frameShort = isPeriodic(typeQ) && (sizeQ != '0);
		tok       = linkIn.token && idle;
		tkRefuse  = tok && (!enQ || nakQ);
		tkZlpFlag = tok && !tkRefuse && zlpQ;
		tkData    = tok && !tkRefuse && !zlpQ && (pktsQ != '0) && !frameShort;
		tkEmpty   = tok && !tkRefuse && !tkZlpFlag && !tkData;
		emptyIrq  = tkEmpty && (isPeriodic(typeQ) || pcntQ == '0);
		ackEv     = linkIn.ack && (stateQ == ST_WAIT);
		toEv      = linkIn.timeout && (stateQ == ST_WAIT);
		isoDone   = (stateQ == ST_SEND) && (sendLeftQ == WCNT_W'(1)) && iso;
		pktDone   = ackEv || isoDone;
		popPkt    = pktDone;
		pcntDec   = (pktDone || tkZlpFlag) && (pcntQ != '0);
		commitLen = wd[LEN_W-1:0];
		commitOk  = wCommit && (pktsQ != PCNT_W'(PKT_MAX));
		// NAK takes hold only between packets; until then data may go out.
		nakEffEv  = nakQ && idle && !nakEffDoneQ;
		disEv     = disReqQ && nakQ && idle;
		xferEv    = enQ && !disReqQ && idle && (sizeQ == '0)
			&& (pcntQ == '0);
		flushEv   = flushQ && idle;
	end

	// =====================================================================
	// Endpoint control
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			enQ     <= 1'b0;
			disReqQ <= 1'b0;
			nakQ    <= 1'b0;
			typeQ   <= TYPE_CTRL;
			mpsQ    <= '0;
		end else begin
			if (wCtrl) begin
				enQ     <= wd[CTRL_EN];
				disReqQ <= wd[CTRL_DIS];
				typeQ   <= wd[CTRL_TYPE +: TYPE_W];
				mpsQ    <= wd[CTRL_MPS +: MPS_W];
				if (wd[CTRL_CLEAR_NAK_REQUEST])
					nakQ <= 1'b0;
				if (wd[CTRL_SET_NAK_REQUEST])
					nakQ <= 1'b1;
			end
			if (xferEv || disEv)
				enQ <= 1'b0;
			if (disEv)
				disReqQ <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			nakEffDoneQ <= 1'b0;
		else if (!nakQ)
			nakEffDoneQ <= 1'b0;
		else if (nakEffEv)
			nakEffDoneQ <= 1'b1;
	end

	// =====================================================================
	// Interrupt status, mask and output
	logic [IRQ_W-1:0] irqSet, irqClr;
	always_comb begin
		irqSet              = '0;
		irqSet[IRQ_XFER]    = xferEv;
		irqSet[IRQ_DIS]     = disEv;
		irqSet[IRQ_TKEMPTY] = emptyIrq;
		irqSet[IRQ_NAKEFF]  = nakEffEv;
		irqSet[IRQ_TXEMPTY] = (usedW == '0);
		irqClr              = wIrq ? wd[IRQ_W-1:0] : '0;
		if (wCtrl && wd[CTRL_CLEAR_NAK_REQUEST])
			irqClr[IRQ_NAKEFF] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irqStsQ  <= '0;
			irqMaskQ <= MASK_RESET;
			irqOut   <= 1'b0;
		end else begin
			// Set wins over a same-cycle clear so no event is lost
			irqStsQ <= (irqStsQ & ~irqClr) | irqSet;
			if (wMask)
				irqMaskQ <= wd[IRQ_W-1:0];
			irqOut <= |(irqStsQ & irqMaskQ);
		end
	end

	// =====================================================================
	// Transfer size and packet count accounting
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sizeQ <= '0;
			pcntQ <= '0;
			mcntQ <= '0;
		end else if (wSize) begin
			sizeQ <= wd[SZ_LO +: SZ_W];
			pcntQ <= wd[PC_LO +: PC_W];
			mcntQ <= wd[MC_LO +: MC_W];
		end else begin
			if (commitOk)
				sizeQ <= (SZ_W'(commitLen) >= sizeQ) ? '0
					: sizeQ - SZ_W'(commitLen);
			if (pcntDec)
				pcntQ <= pcntQ - PC_W'(1);
		end
	end

	// =====================================================================
	// Flush control
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flushQ <= 1'b0;
			fselQ  <= '0;
		end else if (wRst) begin
			flushQ <= wd[RST_FLUSH];
			fselQ  <= wd[RST_FSEL +: FSEL_W];
		end else if (flushEv) begin
			flushQ <= 1'b0;
		end
	end

	// =====================================================================
	// Transmit FIFO: words, packet lengths and zero-length flag
	logic flushOwn;
	assign flushOwn = flushEv && (fselQ == OWN_FIFO_NUM);
	always_ff @(posedge clk) begin
		if (wData && !fifoFull)
			memQ[wrPtrQ[PTR_W-1:0]] <= wd;
		if (commitOk && commitLen != '0)
			lenQ[lenWrQ] <= commitLen;
	end
	always_ff @(posedge clk) begin
		if (!reset_n || flushOwn) begin
			wrPtrQ <= '0;
			lenWrQ <= '0;
			lenRdQ <= '0;
			pktsQ  <= '0;
			zlpQ   <= 1'b0;
		end else begin
			if (wData && !fifoFull)
				wrPtrQ <= wrPtrQ + (PTR_W+1)'(1);
			if (commitOk && commitLen == '0)
				zlpQ <= 1'b1;
			else if (tkZlpFlag)
				zlpQ <= 1'b0;
			if (commitOk && commitLen != '0)
				lenWrQ <= lenWrQ + PQ_W'(1);
			if (popPkt)
				lenRdQ <= lenRdQ + PQ_W'(1);
			if ((commitOk && commitLen != '0) && !popPkt)
				pktsQ <= pktsQ + PCNT_W'(1);
			else if (popPkt && !(commitOk && commitLen != '0))
				pktsQ <= pktsQ - PCNT_W'(1);
		end
	end

	// =====================================================================
	// Link sequencer
	always_ff @(posedge clk) begin
		if (!reset_n || flushOwn) begin
			stateQ    <= ST_IDLE;
			rdPtrQ    <= '0;
			startPtrQ <= '0;
			sendLeftQ <= '0;
		end else begin
			unique case (stateQ)
				ST_IDLE: begin
					if (tkData) begin
						stateQ    <= ST_SEND;
						sendLeftQ <= wordsOf(lenQ[lenRdQ]);
					end else if (tkEmpty)
						rdPtrQ <= startPtrQ;
				end
				ST_SEND: begin
					rdPtrQ    <= rdPtrQ + (PTR_W+1)'(1);
					sendLeftQ <= sendLeftQ - WCNT_W'(1);
					if (sendLeftQ == WCNT_W'(1)) begin
						stateQ <= iso ? ST_IDLE : ST_WAIT;
						if (iso)
							startPtrQ <= rdPtrQ + (PTR_W+1)'(1);
					end
				end
				ST_WAIT: begin
					if (ackEv) begin
						stateQ    <= ST_IDLE;
						startPtrQ <= rdPtrQ;
					end else if (toEv) begin
						stateQ <= ST_IDLE;
						rdPtrQ <= startPtrQ;
					end
				end
			endcase
		end
	end

	// =====================================================================
	// Link outputs
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			resp <= '{valid: 1'b0, kind: RESP_NAK};
			tx   <= '{valid: 1'b0, last: 1'b0, data: 32'h0000_0000};
		end else begin
			resp.valid <= tok;
			if (tkData)
				resp.kind <= RESP_DATA;
			else if (tkZlpFlag || ((tkRefuse || tkEmpty) && iso))
				resp.kind <= RESP_ZLP;
			else
				resp.kind <= RESP_NAK;
			tx.valid <= (stateQ == ST_SEND);
			tx.last  <= (stateQ == ST_SEND) && (sendLeftQ == WCNT_W'(1));
			tx.data  <= memQ[rdPtrQ[PTR_W-1:0]];
		end
	end

endmodule : uiec_in_endpoint

// file: core/uiec_pkg.sv
// Constants, field layout and carrier types of the IN endpoint control block
// Behaviour
// - A set-NAK request stops data on the endpoint even with data queued.
// - In NAK mode: non-isochronous tokens get NAK, isochronous get zero-length.
// - NAK-effective interrupt is raised once set-NAK has taken hold.
// - Clear-NAK leaves NAK mode and clears the NAK-effective interrupt.
// - Data may still go out between set-NAK and NAK-effective.
// - Mask bit 0 suppresses NAK-effective interrupt, 1 allows it.
// - On full disable: disabled interrupt, clear enable and disable request.
// - Flush: software selects FIFO, sets flush bit; device clears it when done.
// - Each packet written lowers remaining transfer size by its length.
// - Count queued packets per FIFO up to eight; zero-length by flag.
// - Acknowledged non-isochronous packet lowers packet count; timeout does not.
// - Zero-length flag: answer token with zero-length packet, lower count.
// - Empty FIFO, count zero: token-empty interrupt unless NAK; NAK, rewind.
// - Size and count both zero: transfer-complete interrupt, clear enable.
// - Periodic token with incomplete data: treat FIFO empty, ZLP or NAK.
// - Sent data equals count drop times max size; fetched equals size drop.
package uiec_pkg;

	// =====================================================================
	// Register map (byte addresses)
	localparam int          ADDR_W     = 6;
	localparam logic [5:0]  A_CTRL     = 6'h00;
	localparam logic [5:0]  A_IRQ      = 6'h04;
	localparam logic [5:0]  A_MASK     = 6'h08;
	localparam logic [5:0]  A_SIZE     = 6'h0C;
	localparam logic [5:0]  A_RSTCTL   = 6'h10;
	localparam logic [5:0]  A_FIFOSTS  = 6'h14;
	localparam logic [5:0]  A_FIFODATA = 6'h18;
	localparam logic [5:0]  A_COMMIT   = 6'h1C;
	localparam logic [3:0]  BE_ALL     = 4'hF;

	// =====================================================================
	// Control register fields
	localparam int CTRL_EN     = 0;
	localparam int CTRL_DIS    = 1;
	localparam int CTRL_SET_NAK_REQUEST   = 2;
	localparam int CTRL_CLEAR_NAK_REQUEST   = 3;
	localparam int CTRL_NAK_STATE_FLAG = 4;
	localparam int CTRL_TYPE   = 5;
	localparam int TYPE_W      = 2;
	localparam int CTRL_MPS    = 16;
	localparam int MPS_W       = 11;
	localparam logic [1:0] TYPE_CTRL = 2'h0;
	localparam logic [1:0] TYPE_ISO  = 2'h1;
	localparam logic [1:0] TYPE_BULK = 2'h2;
	localparam logic [1:0] TYPE_INTR = 2'h3;

	// =====================================================================
	// Interrupt status / mask bits
	localparam int IRQ_W       = 5;
	localparam int IRQ_XFER    = 0;
	localparam int IRQ_DIS     = 1;
	localparam int IRQ_TKEMPTY = 2;
	localparam int IRQ_NAKEFF  = 3;
	localparam int IRQ_TXEMPTY = 4;
	localparam logic [4:0] MASK_RESET = 5'h1F;

	// =====================================================================
	// Size register fields
	localparam int SZ_LO = 0;
	localparam int SZ_W  = 19;
	localparam int PC_LO = 19;
	localparam int PC_W  = 10;
	localparam int MC_LO = 29;
	localparam int MC_W  = 2;

	// =====================================================================
	// Core reset control fields
	localparam int RST_FLUSH = 5;
	localparam int RST_FSEL  = 6;
	localparam int FSEL_W    = 5;
	localparam logic [4:0] OWN_FIFO_NUM = 5'h00;

	// =====================================================================
	// Transmit FIFO
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W      = 4;
	localparam int PKT_MAX    = 8;
	localparam int PQ_W       = 3;
	localparam int PCNT_W     = 4;
	localparam int LEN_W      = 11;
	localparam int WCNT_W     = 10;
	localparam int STS_PKT    = 8;
	localparam int STS_ZLP    = 12;

	// =====================================================================
	// Link carriers
	typedef enum logic [1:0] {RESP_NAK, RESP_DATA, RESP_ZLP} uiec_kind_t;

	typedef struct packed {
		logic       valid;
		uiec_kind_t kind;
	} uiec_resp_t;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic [31:0] data;
	} uiec_tx_t;

	typedef struct packed {
		logic token;
		logic ack;
		logic timeout;
	} uiec_link_in_t;

endpackage : uiec_pkg

// file: verif/uiec_in_endpoint_sva.sv
// Port assertions of the IN endpoint control block
`timescale 1ns/1ps
module uiec_in_endpoint_sva import uiec_pkg::*; (
	input wire logic [ADDR_W-1:0] avs_address,     // Address
	input wire logic              clk,             // Clock
	input wire logic              reset_n,         // Reset
	input wire logic              avs_read,        // Read
	input wire logic              avs_write,       // Write
	input wire logic [31:0]       avs_readdata,    // Read data
	input wire logic              avs_waitrequest, // Stall
	input wire uiec_link_in_t     linkIn,          // Link pulses
	input wire uiec_resp_t        resp,            // Answer
	input wire uiec_tx_t          tx               // Words
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ====================
	// Register bus
	a_wait_one: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	a_wait_pulse: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer too long");
	a_unmapped_zero: assert property (
		avs_read && avs_address[5] && !avs_waitrequest
		|-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// ====================
	// Link side
	a_resp_cause: assert property (
		resp.valid |-> $past(linkIn.token))
		else $error("answer without token");
	a_resp_single: assert property (
		resp.valid |=> !resp.valid)
		else $error("answer longer than one cycle");
	a_data_follows: assert property (
		resp.valid && resp.kind == RESP_DATA |=> tx.valid)
		else $error("data answer without words");
	a_nak_quiet: assert property (
		resp.valid && resp.kind != RESP_DATA |=> !tx.valid [*2])
		else $error("words after empty answer");
	a_words_packed: assert property (
		tx.valid && !tx.last |=> tx.valid)
		else $error("gap inside packet");

	c_data: cover property (resp.valid && resp.kind == RESP_DATA);
	c_zlp: cover property (resp.valid && resp.kind == RESP_ZLP);
	c_nak: cover property (resp.valid && resp.kind == RESP_NAK);
endmodule : uiec_in_endpoint_sva

// file: verif/uiec_host_model.sv
// Host model that issues IN tokens and handshakes
`timescale 1ns/1ps
module uiec_host_model import uiec_pkg::*; (
	input  wire logic       clk,    // Core clock
	output uiec_link_in_t   linkIn, // Token and handshake pulses
	input  wire uiec_resp_t resp,   // Token answer
	input  wire uiec_tx_t   tx      // Packet words
);
	initial linkIn = '0;

	// Handshake hs: 0 none, 1 ack, 2 timeout; kind 3 means no answer
	task automatic token(int hs, output uiec_kind_t k,
		output logic [31:0] w);
		int i;
		k = uiec_kind_t'(2'h3);
		w = 32'h0000_0000;
		@(posedge clk);
		linkIn.token <= 1'b1;
		@(posedge clk);
		linkIn.token <= 1'b0;
		for (i = 0; i < 4 && k == uiec_kind_t'(2'h3); i++) begin
			@(posedge clk);
			if (resp.valid)
				k = resp.kind;
		end
		for (i = 0; i < 64 && k == RESP_DATA; i++) begin
			@(posedge clk);
			if (tx.valid) begin
				w = tx.data;
				if (tx.last)
					break;
			end
		end
		// Handshake only after the last word, one cycle wide
		if (k == RESP_DATA && hs != 0) begin
			linkIn.ack <= (hs == 1);
			linkIn.timeout <= (hs == 2);
			@(posedge clk);
			linkIn <= '0;
		end
	endtask : token
endmodule : uiec_host_model

// file: verif/tb_uiec_in_endpoint.sv
// Self-checking bench of the IN endpoint control block
`timescale 1ns/1ps
module tb_uiec_in_endpoint import uiec_pkg::*;;
	localparam logic [31:0] AL = 32'hFFFF_FFFF;
	localparam int EN = 1 << CTRL_EN;
	localparam int DI = 1 << CTRL_DIS;
	localparam int SN = 1 << CTRL_SET_NAK_REQUEST;
	localparam int CN = 1 << CTRL_CLEAR_NAK_REQUEST;
	localparam int NS = 1 << CTRL_NAK_STATE_FLAG;
	localparam int NE = 1 << IRQ_NAKEFF;
	localparam int XF = 1 << IRQ_XFER;
	localparam int TE = 1 << IRQ_TKEMPTY;
	localparam int DS = 1 << IRQ_DIS;
	localparam int FL = 1 << RST_FLUSH;

	logic          clk = 1'b0;
	logic          reset_n = 1'b0;
	logic [5:0]    busAdr = 6'h00;
	logic          busRd = 1'b0;
	logic          busWr = 1'b0;
	logic [3:0]    busBe = BE_ALL;
	logic [31:0]   busWd = 32'h0000_0000;
	logic [31:0]   rdData;
	logic          busWait;
	logic [31:0]   busQ;
	logic [31:0]   seed = 32'h0000_a41d;
	logic [31:0]   d0;
	int            failCount = 0;
	int            checked = 0;
	uiec_link_in_t linkIn;
	uiec_resp_t    resp;
	uiec_tx_t      tx;
	logic          irqOut;

	always #5 clk = ~clk;

	uiec_in_endpoint i_uiec_in_endpoint (
		.clk            (clk),
		.reset_n        (reset_n),
		.avs_address    (busAdr),
		.avs_read       (busRd),
		.avs_write      (busWr),
		.avs_byteenable (busBe),
		.avs_writedata  (busWd),
		.avs_readdata   (rdData),
		.avs_waitrequest(busWait),
		.linkIn         (linkIn),
		.resp           (resp),
		.tx             (tx),
		.irqOut         (irqOut)
	);

	uiec_host_model i_uiec_host_model (
		.clk   (clk),
		.linkIn(linkIn),
		.resp  (resp),
		.tx    (tx)
	);

	// ====================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Max packet size fixed at 4 bytes, one word a packet
	function automatic logic [31:0] ctl(int f, logic [1:0] ty);
		return 32'(f) | (32'(ty) << CTRL_TYPE) | (32'(4) << CTRL_MPS);
	endfunction : ctl

	function automatic logic [31:0] sz(int s, int c);
		return 32'(s) | (32'(c) << PC_LO);
	endfunction : sz

	task automatic results();
		$display("checked=%0d failCount=%0d", checked, failCount);
		if (failCount == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	task automatic cmp(logic [31:0] g, logic [31:0] e);
		checked++;
		if (g !== e) begin
			failCount++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp

	task automatic bus(logic [5:0] a, logic [31:0] d, logic w = 1'b1);
		int i;
		@(posedge clk);
		busAdr <= a;
		busWd <= d;
		busWr <= w;
		busRd <= !w;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (!busWait)
				break;
		end
		busQ = rdData;
		busWr <= 1'b0;
		busRd <= 1'b0;
		if (i == 16) begin
			failCount++;
			results();
		end
	endtask : bus

	// Polls up to n reads; a field that never settles is a mismatch
	task automatic rdf(logic [5:0] a, logic [31:0] m, logic [31:0] e, int n);
		repeat (n) begin
			bus(a, 32'h0000_0000, 1'b0);
			if ((busQ & m) === e)
				break;
		end
		cmp(busQ & m, e);
	endtask : rdf

	task automatic push(logic [31:0] d);
		bus(A_FIFODATA, d);
		bus(A_COMMIT, 32'h0000_0004);
	endtask : push

	task automatic tok(int hs, uiec_kind_t ek, logic [31:0] ew);
		uiec_kind_t  k;
		logic [31:0] w;
		i_uiec_host_model.token(hs, k, w);
		cmp(32'(k), 32'(ek));
		if (ek == RESP_DATA)
			cmp(w, ew);
	endtask : tok

	// ====================
	// Scenarios
	initial begin
		int i;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		d0 = rnd();
		rdf(A_MASK, AL, 32'(MASK_RESET), 1);
		// A write without all byte lanes is answered but ignored
		busBe <= 4'h3;
		bus(A_MASK, 32'h0000_0000);
		busBe <= BE_ALL;
		rdf(A_MASK, AL, 32'(MASK_RESET), 1);
		rdf(6'h24, AL, 32'h0000_0000, 1);
		// Two bulk packets, the second retried after a timeout
		bus(A_SIZE, sz(8, 2));
		bus(A_CTRL, ctl(EN | CN, TYPE_BULK));
		push(d0);
		push(~d0);
		rdf(A_SIZE, AL, sz(0, 2), 1);
		tok(1, RESP_DATA, d0);
		rdf(A_SIZE, AL, sz(0, 1), 1);
		tok(2, RESP_DATA, ~d0);
		rdf(A_SIZE, AL, sz(0, 1), 1);
		tok(1, RESP_DATA, ~d0);
		rdf(A_IRQ, XF, XF, 4);
		rdf(A_CTRL, EN, 0, 1);
		// Periodic frame one packet short, then flushed
		bus(A_IRQ, 32'h0000_001F);
		bus(A_SIZE, sz(8, 2) | 32'h4000_0000);
		bus(A_CTRL, ctl(EN | CN, TYPE_INTR));
		push(rnd());
		rdf(A_FIFOSTS, 32'h0000_0F00, 32'h0000_0100, 1);
		tok(0, RESP_NAK, 0);
		rdf(A_IRQ, TE, TE, 4);
		bus(A_CTRL, ctl(EN, TYPE_ISO));
		tok(0, RESP_ZLP, 0);
		bus(A_RSTCTL, FL);
		rdf(A_RSTCTL, FL, 0, 8);
		rdf(A_FIFOSTS, 32'h0000_0F1F, 32'h0000_0010, 1);
		// NAK with data waiting and the interrupt masked
		bus(A_IRQ, 32'h0000_001F);
		bus(A_MASK, 32'h0000_0000);
		bus(A_SIZE, sz(4, 1));
		bus(A_CTRL, ctl(EN | CN, TYPE_BULK));
		push(d0);
		bus(A_CTRL, ctl(EN | SN, TYPE_BULK));
		rdf(A_IRQ, NE, NE, 8);
		rdf(A_CTRL, NS, NS, 1);
		cmp(32'(irqOut), 32'h0000_0000);
		tok(0, RESP_NAK, 0);
		bus(A_CTRL, ctl(EN, TYPE_ISO));
		tok(0, RESP_ZLP, 0);
		bus(A_MASK, NE);
		repeat (3) @(posedge clk);
		cmp(32'(irqOut), 32'h0000_0001);
		bus(A_CTRL, ctl(EN | CN, TYPE_ISO));
		rdf(A_IRQ, NE, 0, 4);
		rdf(A_CTRL, NS, 0, 1);
		tok(0, RESP_DATA, d0);
		rdf(A_IRQ, XF, XF, 4);
		// Disable an enabled endpoint
		bus(A_IRQ, 32'h0000_001F);
		bus(A_SIZE, sz(4, 1));
		bus(A_CTRL, ctl(EN | CN, TYPE_BULK));
		bus(A_CTRL, ctl(EN | SN, TYPE_BULK));
		rdf(A_IRQ, NE, NE, 8);
		bus(A_CTRL, ctl(EN | DI | SN, TYPE_BULK));
		rdf(A_IRQ, DS, DS, 8);
		rdf(A_CTRL, EN | DI, 0, 1);
		// Lone zero-length packet on a bulk endpoint
		bus(A_IRQ, 32'h0000_001F);
		bus(A_SIZE, sz(0, 1));
		bus(A_CTRL, ctl(EN | CN, TYPE_BULK));
		bus(A_COMMIT, 32'h0000_0000);
		rdf(A_FIFOSTS, 1 << STS_ZLP, 1 << STS_ZLP, 1);
		tok(0, RESP_ZLP, 0);
		rdf(A_SIZE, AL, 32'h0000_0000, 1);
		rdf(A_IRQ, XF, XF, 4);
		// Periodic lone zero-length packet, multi-count one, then the queue limit
		bus(A_IRQ, 32'h0000_001F);
		bus(A_SIZE, sz(0, 1) | 32'h2000_0000);
		bus(A_CTRL, ctl(EN | CN, TYPE_ISO));
		bus(A_COMMIT, 32'h0000_0000);
		tok(0, RESP_ZLP, 0);
		rdf(A_IRQ, XF, XF, 4);
		for (i = 0; i < 9; i++)
			push(rnd());
		rdf(A_FIFOSTS, 32'h0000_0F1F, 32'h0000_0807, 1);
		// Flushing another FIFO only clears the flush bit
		bus(A_RSTCTL, FL | (1 << RST_FSEL));
		rdf(A_RSTCTL, FL, 0, 8);
		rdf(A_FIFOSTS, 32'h0000_0F1F, 32'h0000_0807, 1);
		bus(A_RSTCTL, FL);
		rdf(A_RSTCTL, FL, 0, 8);
		rdf(A_FIFOSTS, 32'h0000_1F1F, 32'h0000_0010, 1);
		results();
	end
endmodule : tb_uiec_in_endpoint

bind uiec_in_endpoint uiec_in_endpoint_sva i_uiec_in_endpoint_sva (
	.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.linkIn(linkIn), .resp(resp), .tx(tx)
);
